// ---- core/shpc_monitor.sv ----
// current and power arithmetic with a two-wire serial slave register port
//
// Behaviour
// - current = shunt times scale, divided by 2048
// - power = current magnitude times supply level, /20000
// - supply level at pointer 02h, fixed scale
// - supply level top bit always reads zero
// - power 03h, current 04h, scale 05h readable
// - no valid current/power before scale written
// - results zero until scale is written
// - default config 4127h runs continuous conversions
// - all registers volatile, defaults at reset
// - address sampled on rise, ack on ninth
// - eight bits plus ack; SDA change decoded
// - 28 ms timeout resets serial state
// - first byte: seven address bits plus direction
// - straps decode four levels into address bits
// - straps sampled on every transaction
// - write: pointer, then MSB, LSB, each acked
// - read returns pointed register, MSB first
module shpc_monitor
    import shpc_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC       // bus stall limit in clocks
) (
    input  wire logic        clk,                // system clock
    input  wire logic        reset_n,            // synchronous reset, active low
    input  wire logic        scl_in,             // serial clock pin level
    input  wire logic        sda_in,             // serial data pin level
    output logic             sda_out,            // data drive value, always low
    output logic             sda_oe,             // high while pulling data low
    input  wire logic        addr_strap_low_in,  // low address strap pin level
    input  wire logic        addr_strap_high_in, // high address strap pin level
    input  wire logic [15:0] shunt_sample,       // new shunt drop conversion
    input  wire logic [15:0] supply_sample,      // new supply level conversion
    input  wire logic        sample_valid,       // one-cycle pulse, samples valid
    output logic [15:0]      op_config,          // operating configuration
    output logic             result_valid        // scale factor programmed
);

    // pin synchronisers; stage 3 only feeds edge detection
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [1:0]  sl_s;
    logic [1:0]  sh_s;

    shpc_state_t state_r;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [15:0] tx_sh_r;
    logic        rw_r;
    logic        nack_r;
    logic [1:0]  byte_idx_r;
    logic        sda_oe_r;
    logic        rx_stb_r;
    logic [1:0]  rx_idx_r;
    logic [7:0]  rx_byte_r;

    logic [7:0]  ptr_r;
    logic [7:0]  msb_hold_r;
    logic [15:0] config_r;
    logic [15:0] scale_r;
    logic        scale_set_r;
    logic [15:0] shunt_r;
    logic [15:0] supply_r;
    logic [15:0] current_r;
    logic [15:0] power_r;
    logic        calc_cur_r;
    logic        calc_pwr_r;

    logic [1:0]  d_sda_r;
    logic [1:0]  d_scl_r;
    logic [1:0]  seen1_r;
    logic [19:0] to_cnt_r;
    logic        to_hit;

    logic        scl_rise;
    logic        scl_fall;
    logic        start_ev;
    logic        stop_ev;
    logic [6:0]  my_addr;
    logic [15:0] rd_word;
    logic [15:0] wr_word;
    logic        wr_stb;
    logic        soft_rst;

    // two flops before any logic reads a pin
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            sl_s  <= 2'h0;
            sh_s  <= 2'h0;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            sl_s  <= {sl_s[0], addr_strap_low_in};
            sh_s  <= {sh_s[0], addr_strap_high_in};
        end
    end

    // bus events; data change while clock high is start or stop
    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    assign start_ev = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop_ev  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

    // strap level tracking; restarted at every start condition
    always_ff @(posedge clk) begin
        if (!reset_n || start_ev) begin
            d_sda_r <= 2'h0;
            d_scl_r <= 2'h0;
            seen1_r <= 2'h0;
        end else if (state_r == SHPC_ADDR) begin
            d_sda_r <= d_sda_r | {sh_s[1] ^ sda_s[1], sl_s[1] ^ sda_s[1]};
            d_scl_r <= d_scl_r | {sh_s[1] ^ scl_s[1], sl_s[1] ^ scl_s[1]};
            seen1_r <= seen1_r | {sh_s[1], sl_s[1]};
        end
    end

    // a strap that tracked a bus line is tied to it, else a rail
    function automatic logic [1:0] strap_code(input logic dsda, input logic dscl,
                                              input logic hi);
        if (!dsda)
            strap_code = STRAP_SDA;
        else if (!dscl)
            strap_code = STRAP_SCL;
        else if (hi)
            strap_code = STRAP_SUPPLY;
        else
            strap_code = STRAP_GND;
    endfunction

    assign my_addr = SLAVE_BASE |
                     {3'h0, strap_code(d_sda_r[1], d_scl_r[1], seen1_r[1]),
                      strap_code(d_sda_r[0], d_scl_r[0], seen1_r[0])};

    // stall watchdog, cleared by any clock edge or idle bus
    always_ff @(posedge clk) begin
        if (!reset_n || state_r == SHPC_IDLE || scl_rise || scl_fall)
            to_cnt_r <= 20'h00000;
        else if (!to_hit)
            to_cnt_r <= to_cnt_r + 20'h00001;
    end
    assign to_hit = (to_cnt_r == 20'(TIMEOUT_CYCLES - 1));

    // serial state machine; data is driven only after a falling edge
    always_ff @(posedge clk) begin
        rx_stb_r <= 1'b0;
        if (!reset_n || to_hit) begin
            state_r    <= SHPC_IDLE;
            sda_oe_r   <= 1'b0;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            tx_sh_r    <= WORD_ZERO;
            rw_r       <= 1'b0;
            nack_r     <= 1'b0;
            byte_idx_r <= 2'h0;
            rx_idx_r   <= 2'h0;
            rx_byte_r  <= 8'h00;
        end else if (start_ev) begin
            state_r   <= SHPC_ADDR;
            sda_oe_r  <= 1'b0;
            bit_cnt_r <= 4'h0;
        end else if (stop_ev) begin
            state_r  <= SHPC_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            case (state_r)
                SHPC_ADDR: begin
                    if (scl_rise) begin
                        shift_r   <= {shift_r[6:0], sda_s[1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == 4'(BYTE_BITS)) begin
                        if (shift_r[7:1] == my_addr) begin
                            rw_r       <= shift_r[0];
                            sda_oe_r   <= 1'b1;
                            byte_idx_r <= 2'h0;
                            state_r    <= SHPC_AACK;
                        end else begin
                            state_r <= SHPC_IDLE;
                        end
                    end
                end
                SHPC_AACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        if (rw_r) begin
                            tx_sh_r  <= rd_word;
                            sda_oe_r <= ~rd_word[15];
                            state_r  <= SHPC_TX;
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r  <= SHPC_RX;
                        end
                    end
                end
                SHPC_RX: begin
                    if (scl_rise) begin
                        shift_r   <= {shift_r[6:0], sda_s[1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end else if (scl_fall && bit_cnt_r == 4'(BYTE_BITS)) begin
                        rx_stb_r  <= 1'b1;
                        rx_idx_r  <= byte_idx_r;
                        rx_byte_r <= shift_r;
                        sda_oe_r  <= 1'b1;
                        state_r   <= SHPC_RACK;
                        if (byte_idx_r != 2'h3)
                            byte_idx_r <= byte_idx_r + 2'h1;
                    end
                end
                SHPC_RACK: begin
                    if (scl_fall) begin
                        sda_oe_r  <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        state_r   <= SHPC_RX;
                    end
                end
                SHPC_TX: begin
                    if (scl_fall) begin
                        tx_sh_r   <= {tx_sh_r[14:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'(BYTE_BITS - 1)) begin
                            sda_oe_r <= 1'b0;
                            state_r  <= SHPC_MACK;
                        end else begin
                            sda_oe_r <= ~tx_sh_r[14];
                        end
                    end
                end
                SHPC_MACK: begin
                    if (scl_rise) begin
                        nack_r <= sda_s[1];
                    end else if (scl_fall) begin
                        bit_cnt_r  <= 4'h0;
                        byte_idx_r <= {1'b0, ~byte_idx_r[0]};
                        if (nack_r) begin
                            state_r <= SHPC_IDLE;
                        end else if (byte_idx_r[0]) begin
                            // word sent whole; a further read repeats it fresh
                            tx_sh_r  <= rd_word;
                            sda_oe_r <= ~rd_word[15];
                            state_r  <= SHPC_TX;
                        end else begin
                            sda_oe_r <= ~tx_sh_r[15];
                            state_r  <= SHPC_TX;
                        end
                    end
                end
                default: begin
                    state_r <= SHPC_IDLE;
                end
            endcase
        end
    end

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_r;

    // pointer from first data byte, high byte held for the low one
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ptr_r      <= PTR_CONFIG;
            msb_hold_r <= 8'h00;
        end else if (rx_stb_r) begin
            if (rx_idx_r == 2'h0)
                ptr_r <= rx_byte_r;
            else if (rx_idx_r == 2'h1)
                msb_hold_r <= rx_byte_r;
        end
    end

    // third byte completes the word; bytes beyond are acked, dropped
    assign wr_stb   = rx_stb_r && rx_idx_r == 2'h2;
    assign wr_word  = {msb_hold_r, rx_byte_r};
    assign soft_rst = wr_stb && ptr_r == PTR_CONFIG && wr_word[CFG_SOFT_RST];

    // configuration; its top bit returns every register except the pointer to default
    always_ff @(posedge clk) begin
        if (!reset_n || soft_rst)
            config_r <= CONFIG_RST;
        else if (wr_stb && ptr_r == PTR_CONFIG)
            config_r <= wr_word;
    end

    // scale factor and the flag that releases the results
    always_ff @(posedge clk) begin
        if (!reset_n || soft_rst) begin
            scale_r     <= WORD_ZERO;
            scale_set_r <= 1'b0;
        end else if (wr_stb && ptr_r == PTR_SCALE) begin
            scale_r     <= wr_word;
            scale_set_r <= 1'b1;
        end
    end

    // conversion capture, gated by the enabled channels
    always_ff @(posedge clk) begin
        if (!reset_n || soft_rst) begin
            shunt_r    <= WORD_ZERO;
            supply_r   <= WORD_ZERO;
            calc_cur_r <= 1'b0;
            calc_pwr_r <= 1'b0;
        end else begin
            calc_cur_r <= sample_valid;
            calc_pwr_r <= calc_cur_r;
            if (sample_valid && config_r[CFG_SHUNT_EN])
                shunt_r <= shunt_sample;
            if (sample_valid && config_r[CFG_BUS_EN]) begin
                supply_r             <= supply_sample;
                supply_r[SUPPLY_MSB] <= 1'b0;
            end
        end
    end

    // arithmetic: 33-bit signed and 32-bit unsigned products, no overflow
    logic signed [32:0] cur_prod;
    logic signed [32:0] cur_quot;
    logic        [16:0] cur_mag;
    logic        [31:0] pwr_prod;
    logic        [31:0] pwr_quot;

    assign cur_prod = $signed(shunt_r) * $signed({1'b0, scale_r});
    assign cur_quot = cur_prod / 33'(CURRENT_DIV);
    assign cur_mag  = current_r[15] ? 17'(-$signed(current_r)) : {1'b0, current_r};
    assign pwr_prod = 32'(cur_mag[15:0]) * 32'(supply_r);
    assign pwr_quot = pwr_prod / 32'(POWER_DIV);

    // results update one and two cycles after a sample pair
    always_ff @(posedge clk) begin
        if (!reset_n || soft_rst || !scale_set_r) begin
            current_r <= WORD_ZERO;
            power_r   <= WORD_ZERO;
        end else begin
            if (calc_cur_r)
                current_r <= cur_quot[15:0];
            if (calc_pwr_r)
                power_r <= pwr_quot[15:0];
        end
    end

    // read mux; unmapped pointers read zero
    always_comb begin
        case (ptr_r)
            PTR_CONFIG:  rd_word = config_r;
            PTR_SHUNT:   rd_word = shunt_r;
            PTR_SUPPLY:  rd_word = supply_r;
            PTR_POWER:   rd_word = power_r;
            PTR_CURRENT: rd_word = current_r;
            PTR_SCALE:   rd_word = scale_r;
            default:     rd_word = WORD_ZERO;
        endcase
    end

    assign op_config    = config_r;
    assign result_valid = scale_set_r;

endmodule

// ---- inc/shpc_pkg.sv ----
// constants, register map and state type of the shunt power monitor block
package shpc_pkg;
    // register pointers
    localparam logic [7:0]  PTR_CONFIG   = 8'h00;
    localparam logic [7:0]  PTR_SHUNT    = 8'h01;
    localparam logic [7:0]  PTR_SUPPLY   = 8'h02;
    localparam logic [7:0]  PTR_POWER    = 8'h03;
    localparam logic [7:0]  PTR_CURRENT  = 8'h04;
    localparam logic [7:0]  PTR_SCALE    = 8'h05;
    // reset values
    localparam logic [15:0] CONFIG_RST   = 16'h4127;
    localparam logic [15:0] WORD_ZERO    = 16'h0000;
    // configuration fields
    localparam int          CFG_SOFT_RST = 15;
    localparam int          CFG_SHUNT_EN = 0;
    localparam int          CFG_BUS_EN   = 1;
    localparam int          SUPPLY_MSB   = 15;
    // arithmetic divisors
    localparam int          CURRENT_DIV  = 2048;
    localparam int          POWER_DIV    = 20000;
    // slave address: base with strap codes in bits 3:2 and 1:0
    localparam logic [6:0]  SLAVE_BASE   = 7'h40;
    localparam logic [1:0]  STRAP_GND    = 2'h0;
    localparam logic [1:0]  STRAP_SUPPLY = 2'h1;
    localparam logic [1:0]  STRAP_SDA    = 2'h2;
    localparam logic [1:0]  STRAP_SCL    = 2'h3;
    // serial timing
    localparam int          BYTE_BITS    = 8;
    localparam int          CLK_HZ       = 25000000;
    localparam int          TIMEOUT_MS   = 28;
    localparam int          TIMEOUT_CYC  = TIMEOUT_MS * (CLK_HZ / 1000);
    // serial state machine
    typedef enum logic [2:0] {
        SHPC_IDLE,
        SHPC_ADDR,
        SHPC_AACK,
        SHPC_RX,
        SHPC_RACK,
        SHPC_TX,
        SHPC_MACK
    } shpc_state_t;
endpackage

// ---- sim/shpc_host.sv ----
// two-wire bus master model, paced by the bench clock
module shpc_host (
    input  wire logic clk,      // pacing clock
    input  wire logic sda_wire, // resolved data line
    output logic      scl,      // serial clock
    output logic      sda_low   // pulls data low
);
    timeunit 1ns;
    timeprecision 1ns;
    // clock stands high outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic start();
        sda_low = 1'b1;
        wt(4);
        scl = 1'b0;
    endtask
    // data moves one clock after the fall, read mid-high
    task automatic bitx(input logic b, output logic s);
        wt(1);
        sda_low = !b;
        wt(3);
        scl = 1'b1;
        wt(2);
        s = sda_wire;
        wt(2);
        scl = 1'b0;
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(d[i], s);
        bitx(1'b1, s);
        ack = !s;
    endtask
    // last byte answered with no-ack to end the read
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(last, s);
    endtask
    task automatic stop();
        wt(1);
        sda_low = 1'b1;
        wt(3);
        scl = 1'b1;
        wt(4);
        sda_low = 1'b0;
        wt(4);
    endtask
endmodule

// ---- sim/shpc_monitor_properties.sv ----
// pin-level assertions for the monitor
module shpc_monitor_properties
    import shpc_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC // stall limit
) (
    input wire logic        clk,                // clock
    input wire logic        reset_n,            // reset
    input wire logic        scl_in,             // clock pin
    input wire logic        sda_in,             // data pin
    input wire logic        sda_out,            // drive value
    input wire logic        sda_oe,             // drive enable
    input wire logic        addr_strap_low_in,  // strap
    input wire logic        addr_strap_high_in, // strap
    input wire logic [15:0] shunt_sample,       // shunt in
    input wire logic [15:0] supply_sample,      // supply in
    input wire logic        sample_valid,       // strobe
    input wire logic [15:0] op_config,          // config
    input wire logic        result_valid        // scale set
);
    timeunit 1ns;
    timeprecision 1ns;
    int hold_r; // drive cycles with a still clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // a stalled master must not pin the data line forever
    always_ff @(posedge clk) begin
        if (!reset_n || !sda_oe || $changed(scl_in)) begin
            hold_r <= 0;
        end else begin
            hold_r <= hold_r + 1;
        end
    end
    drive_low_a: assert property (sda_oe |-> !sda_out)
        else $error("data line driven high");
    reset_values_a: assert property (
        $rose(reset_n) |-> op_config == CONFIG_RST && !result_valid && !sda_oe)
        else $error("bad state after reset");
    drive_on_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive moved with clock high");
    // words land two clocks after the last byte's fall, while its ack is driven
    config_on_low_a: assert property ($changed(op_config) |-> sda_oe)
        else $error("config moved outside a byte ack");
    valid_set_a: assert property ($rose(result_valid) |-> sda_oe)
        else $error("scale flag set outside a write");
    valid_kept_a: assert property (
        $fell(result_valid) |-> op_config == CONFIG_RST)
        else $error("scale flag lost without reset");
    ack_stands_a: assert property ($rose(sda_oe) |=> sda_oe [*6])
        else $error("drive released too early");
    stall_free_a: assert property (hold_r < TIMEOUT_CYCLES + 16)
        else $error("data held past bus timeout");
    cover property ($rose(result_valid));
    cover property ($rose(sda_oe));
    cover property ($fell(result_valid));
endmodule
bind shpc_monitor shpc_monitor_properties #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
    i_shpc_monitor_properties (.clk, .reset_n, .scl_in, .sda_in, .sda_out,
    .sda_oe, .addr_strap_low_in, .addr_strap_high_in, .shunt_sample,
    .supply_sample, .sample_valid, .op_config, .result_valid);

// ---- sim/tb_top.sv ----
// self-checking bench for the shunt power monitor
module tb_top
    import shpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TMO = 2000;
    logic clk, reset_n, scl, m_low, sda_out, sda_oe, sample_valid, result_valid;
    logic [1:0]  lo_sel, hi_sel;
    logic [15:0] shunt_sample, supply_sample, op_config;
    logic [7:0]  last_ptr;
    logic [6:0]  dev_addr;
    wire         sda_wire, strap_lo, strap_hi;
    int          err_total, checks_done, cyc;
    // open-drain data line with pull-up; straps to gnd, supply, data or clock
    assign sda_wire = !(m_low || (sda_oe && !sda_out));
    assign strap_lo = lo_sel[1] ? (lo_sel[0] ? scl : sda_wire) : lo_sel[0];
    assign strap_hi = hi_sel[1] ? (hi_sel[0] ? scl : sda_wire) : hi_sel[0];
    shpc_monitor #(.TIMEOUT_CYCLES(TMO)) i_shpc_monitor (.clk(clk), .reset_n(reset_n),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .addr_strap_low_in(strap_lo), .addr_strap_high_in(strap_hi),
        .shunt_sample(shunt_sample), .supply_sample(supply_sample),
        .sample_valid(sample_valid), .op_config(op_config), .result_valid(result_valid));
    shpc_host i_shpc_host (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_low(m_low));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // run ceiling against a hang
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_total++;
            close_out();
        end
    end
    task automatic close_out();
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", what, e, g);
            err_total++;
        end
    endtask
    task automatic send(input logic [7:0] d, inout logic ok);
        logic a;
        i_shpc_host.wr_byte(d, a);
        ok = ok & a;
    endtask
    task automatic reg_write(input logic [7:0] p, input logic [15:0] v);
        logic ok;
        ok = 1'b1;
        i_shpc_host.start();
        send({dev_addr, 1'b0}, ok);
        send(p, ok);
        send(v[15:8], ok);
        send(v[7:0], ok);
        i_shpc_host.stop();
        check("write acks", 16'h1, {15'h0, ok});
    endtask
    task automatic set_ptr(input logic [7:0] p);
        logic ok;
        ok = 1'b1;
        last_ptr = p;
        i_shpc_host.start();
        send({dev_addr, 1'b0}, ok);
        send(p, ok);
        i_shpc_host.stop();
        check("pointer acks", 16'h1, {15'h0, ok});
    endtask
    task automatic again(input logic [15:0] e);
        logic ok;
        logic [15:0] v;
        i_shpc_host.start();
        send({dev_addr, 1'b1}, ok);
        i_shpc_host.rd_byte(1'b0, v[15:8]);
        i_shpc_host.rd_byte(1'b1, v[7:0]);
        i_shpc_host.stop();
        check($sformatf("word %h", last_ptr), e, v);
    endtask
    task automatic expect_reg(input logic [7:0] p, input logic [15:0] e);
        set_ptr(p);
        again(e);
    endtask
    task automatic pulse(input logic [15:0] sh, input logic [15:0] su);
        shunt_sample = sh;
        supply_sample = su;
        sample_valid = 1'b1;
        @(negedge clk);
        sample_valid = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    task automatic t_calc();
        check("config port", CONFIG_RST, op_config);
        expect_reg(PTR_CONFIG, CONFIG_RST);
        pulse(16'h1f40, 16'h2570);
        expect_reg(PTR_CURRENT, WORD_ZERO);
        expect_reg(PTR_POWER, WORD_ZERO);
        reg_write(PTR_SCALE, 16'h0a00);
        check("valid", 16'h1, {15'h0, result_valid});
        expect_reg(PTR_SCALE, 16'h0a00);
        pulse(16'h1f40, 16'ha570);
        expect_reg(PTR_CURRENT, 16'h2710);
        expect_reg(PTR_POWER, 16'h12b8);
        expect_reg(PTR_SUPPLY, 16'h2570);
        again(16'h2570);
        pulse(16'he0c0, 16'h2570);
        expect_reg(PTR_CURRENT, 16'hd8f0);
        expect_reg(PTR_POWER, 16'h12b8);
    endtask
    // captures off, then a soft reset back to defaults
    task automatic t_config();
        reg_write(PTR_CONFIG, 16'h4124);
        check("config port", 16'h4124, op_config);
        pulse(16'h0100, 16'h0100);
        expect_reg(PTR_SHUNT, 16'he0c0);
        reg_write(PTR_CONFIG, 16'h8000);
        check("config port", CONFIG_RST, op_config);
        check("valid", 16'h0, {15'h0, result_valid});
        expect_reg(PTR_SCALE, WORD_ZERO);
    endtask
    task automatic t_strap();
        logic a;
        for (int c = 0; c < 4; c++) begin
            lo_sel = 2'(c);
            hi_sel = 2'(3 - c);
            dev_addr = SLAVE_BASE | 7'({hi_sel, lo_sel});
            expect_reg(PTR_CONFIG, CONFIG_RST);
        end
        i_shpc_host.start();
        i_shpc_host.wr_byte({dev_addr ^ 7'h20, 1'b0}, a);
        i_shpc_host.stop();
        check("foreign ack", 16'h0, {15'h0, a});
    endtask
    // extra data byte dropped, two words in one read, unmapped pointer
    task automatic t_burst();
        logic ok;
        logic [31:0] v;
        ok = 1'b1;
        i_shpc_host.start();
        send({dev_addr, 1'b0}, ok);
        send(PTR_SCALE, ok);
        send(8'h12, ok);
        send(8'h34, ok);
        send(8'h56, ok);
        i_shpc_host.stop();
        check("extra byte acks", 16'h1, {15'h0, ok});
        i_shpc_host.start();
        send({dev_addr, 1'b1}, ok);
        for (int i = 3; i >= 0; i--) i_shpc_host.rd_byte(i == 0, v[8*i +: 8]);
        i_shpc_host.stop();
        check("read ack", 16'h1, {15'h0, ok});
        check("first word", 16'h1234, v[31:16]);
        check("second word", 16'h1234, v[15:0]);
        expect_reg(8'h07, WORD_ZERO);
    endtask
    // master stalls with the device driving a zero bit
    task automatic t_timeout();
        logic ok;
        set_ptr(PTR_CONFIG);
        i_shpc_host.start();
        send({dev_addr, 1'b1}, ok);
        repeat (8) @(negedge clk);
        check("drive held", 16'h1, {15'h0, sda_oe});
        repeat (TMO + 40) @(negedge clk);
        check("drive freed", 16'h0, {15'h0, sda_oe});
        i_shpc_host.stop();
        expect_reg(PTR_CONFIG, CONFIG_RST);
    endtask
    initial begin
        cyc = 0;
        err_total = 0;
        checks_done = 0;
        reset_n = 1'b0;
        lo_sel = 2'h1;
        hi_sel = 2'h0;
        dev_addr = 7'h41;
        shunt_sample = 16'h0;
        supply_sample = 16'h0;
        sample_valid = 1'b0;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (6) @(negedge clk);
        t_calc();
        t_config();
        t_strap();
        t_burst();
        t_timeout();
        close_out();
    end
endmodule
